// >>> logic/pwm_pkg.sv
// Shared constants and types for the single-channel 10-bit PWM unit.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package pwm_pkg;

  // Bus shape. Each register is one aligned word at byte address index * 4.
  localparam int DATA_W = 32;
  localparam int REG_SPAN_BITS = 5;
  localparam logic [3:0] REG_NONE = 4'h8;

  // Register word indices.
  localparam logic [2:0] IDX_COUNT = 3'h0;
  localparam logic [2:0] IDX_PERIOD = 3'h1;
  localparam logic [2:0] IDX_TBCTL = 3'h2;
  localparam logic [2:0] IDX_DUTYW = 3'h3;
  localparam logic [2:0] IDX_SHADOW = 3'h4;
  localparam logic [2:0] IDX_MODCTL = 3'h5;
  localparam logic [2:0] IDX_TSELA = 3'h6;
  localparam logic [2:0] IDX_TSELB = 3'h7;

  // Field positions in the time base control register.
  localparam int TB_PRE_LSB = 0;
  localparam int TB_RUN_BIT = 2;
  localparam int TB_POST_LSB = 3;
  localparam int TB_FLAG_BIT = 7;
  localparam int TB_CFG_W = 7;

  // Field positions in the module control register.
  localparam int MC_MODE_LSB = 0;
  localparam int MC_MODE_TOP_LSB = 2;
  localparam int MC_DUTY_LSB = 4;
  localparam int MC_DRIVE_BIT = 7;
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam logic [3:0] MODE_OFF = 4'h0;

  // Prescale select codes and the last sub-count of each factor (4 * factor - 1).
  localparam logic [1:0] PRE_1 = 2'h0;
  localparam logic [1:0] PRE_4 = 2'h1;
  localparam logic [5:0] SUB_LAST_1 = 6'h03;
  localparam logic [5:0] SUB_LAST_4 = 6'h0f;
  localparam logic [5:0] SUB_LAST_16 = 6'h3f;

  // Reset values.
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] REG8_RESET = 8'h00;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Ten-bit duty: eight upper bits and the two hidden low bits.
  typedef struct packed {
    logic [7:0] high;
    logic [1:0] low;
  } duty_type;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_type;

endpackage

// >>> logic/ccp_pwm_10bit.sv
// Single-channel 10-bit PWM generator with its 8-bit period timer and AXI4-Lite registers.
// Assumes the bus master follows AXI4-Lite and that clock is the oscillator clock.
//
// Overview of operation
// - Time base is the 8-bit timer count extended by two prescaler/phase bits.
// - The period comes from the software-written 8-bit period limit register.
// - When the count equals the limit, the next increment clears the count.
// - That rollover sets the output pin, unless the duty value is zero.
// - Each rollover in PWM mode copies the written duty value into the duty shadow.
// - The postscaler never changes the PWM period; it only paces a flag.
// - Duty is eight bits from the duty register plus control bits 5:4.
// - High time equals duty times oscillator period times prescale factor.
// - Duty writes are accepted anytime but applied only at period end.
// - In PWM mode the duty shadow ignores software writes.
// - Shadow plus hidden two-bit latch double-buffer the duty without glitches.
// - Output clears when shadow duty with latch equals the 10-bit time base.
// - Duty beyond the period never clears the output; it stays high.
// - Prescale factors of 1, 4 or 16 are offered.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ccp_pwm_10bit
  import pwm_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset and clock enable.
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clockEn,
  // AXI4-Lite write address and data.
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W/8-1:0] wstrb,
  // AXI4-Lite write response.
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read.
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // PWM output pin.
  output logic pwmOutputPin,
  output logic pwmOutputPinOe
);

  if (ADDR_W < REG_SPAN_BITS) begin : gen_addr_check
    $error("ADDR_W must cover the register span");
  end

  function automatic logic [3:0] decodeReg(input logic [ADDR_W-1:0] a);
    decodeReg = REG_NONE;
    if ((a >> REG_SPAN_BITS) == '0 && a[1:0] == 2'b00) begin
      decodeReg = {1'b0, a[4:2]};
    end
  endfunction

  function automatic logic [5:0] subLast(input logic [1:0] pre);
    unique case (pre)
      PRE_1: subLast = SUB_LAST_1;
      PRE_4: subLast = SUB_LAST_4;
      default: subLast = SUB_LAST_16;
    endcase
  endfunction

  // The two low bits run at one step per prescale factor of oscillator cycles.
  function automatic logic [1:0] lowBits(input logic [5:0] sub, input logic [1:0] pre);
    unique case (pre)
      PRE_1: lowBits = sub[1:0];
      PRE_4: lowBits = sub[3:2];
      default: lowBits = sub[5:4];
    endcase
  endfunction

  // Registers.
  logic [7:0] count_r;
  logic [7:0] period_r;
  logic [TB_CFG_W-1:0] tbCtl_r;
  logic postFlag_r;
  logic [7:0] dutyWrite_r;
  logic [7:0] modCtl_r;
  logic [7:0] tselA_r;
  logic [7:0] tselB_r;
  duty_type shadow_r;
  logic [5:0] sub_r;
  logic [3:0] post_r;
  logic pwmPin_r;
  logic pwmPinOe_r;

  // Bus state.
  logic awready_r;
  logic wready_r;
  logic awHave_r;
  logic wHave_r;
  logic [ADDR_W-1:0] awAddr_r;
  logic [7:0] wData_r;
  logic wStrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  rd_state_type rdState_r;
  logic arready_r;
  logic rvalid_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;

  // Control decode.
  wire logic [1:0] preSel = tbCtl_r[TB_PRE_LSB +: 2];
  wire logic runOn = tbCtl_r[TB_RUN_BIT];
  wire logic [3:0] postSel = tbCtl_r[TB_POST_LSB +: 4];
  wire logic pwmMode = modCtl_r[MC_MODE_TOP_LSB +: 2] == MODE_PWM;
  wire logic modeOff = modCtl_r[MC_MODE_LSB +: 4] == MODE_OFF;
  duty_type dutyNew;
  assign dutyNew = '{high: dutyWrite_r, low: modCtl_r[MC_DUTY_LSB +: 2]};

  // Timer events.
  wire logic subEnd = sub_r >= subLast(preSel);
  wire logic tick = clockEn && runOn && subEnd;
  wire logic atLimit = count_r == period_r;
  wire logic rollEv = tick && atLimit;
  wire logic [9:0] timeBase = {count_r, lowBits(sub_r, preSel)};
  wire logic matchEv = clockEn && pwmMode && timeBase == shadow_r;
  wire logic postEnd = post_r == postSel;
  wire logic postEv = rollEv && postEnd;

  // Write decode.
  wire logic wrFire = clockEn && awHave_r && wHave_r && !bvalid_r;
  wire logic [3:0] wrIdx = decodeReg(awAddr_r);
  wire logic wrEn = wrFire && wStrb0_r;
  wire logic wrCount = wrEn && wrIdx == {1'b0, IDX_COUNT};
  wire logic wrPeriod = wrEn && wrIdx == {1'b0, IDX_PERIOD};
  wire logic wrTb = wrEn && wrIdx == {1'b0, IDX_TBCTL};
  wire logic wrDutyW = wrEn && wrIdx == {1'b0, IDX_DUTYW};
  wire logic wrShadow = wrEn && wrIdx == {1'b0, IDX_SHADOW};
  wire logic wrModCtl = wrEn && wrIdx == {1'b0, IDX_MODCTL};
  wire logic wrTselA = wrEn && wrIdx == {1'b0, IDX_TSELA};
  wire logic wrTselB = wrEn && wrIdx == {1'b0, IDX_TSELB};

  // Read decode.
  wire logic [3:0] rdIdx = decodeReg(araddr);
  wire logic rdHit = rdIdx != REG_NONE;
  wire logic [7:0] rdByte =
    (rdIdx == {1'b0, IDX_COUNT}) ? count_r :
    (rdIdx == {1'b0, IDX_PERIOD}) ? period_r :
    (rdIdx == {1'b0, IDX_TBCTL}) ? {postFlag_r, tbCtl_r} :
    (rdIdx == {1'b0, IDX_DUTYW}) ? dutyWrite_r :
    (rdIdx == {1'b0, IDX_SHADOW}) ? shadow_r.high :
    (rdIdx == {1'b0, IDX_MODCTL}) ? modCtl_r :
    (rdIdx == {1'b0, IDX_TSELA}) ? tselA_r :
    (rdIdx == {1'b0, IDX_TSELB}) ? tselB_r : REG8_RESET;

  // Period timer: a software write to the count restarts the prescaler.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_r <= REG8_RESET;
      sub_r <= '0;
    end else if (clockEn) begin
      if (wrCount) begin
        count_r <= wData_r;
        sub_r <= '0;
      end else if (runOn) begin
        if (subEnd) begin
          sub_r <= '0;
          count_r <= atLimit ? REG8_RESET : count_r + 8'h01;
        end else begin
          sub_r <= sub_r + 6'h01;
        end
      end
    end
  end

  // Software registers.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      period_r <= PERIOD_RESET;
      tbCtl_r <= '0;
      dutyWrite_r <= REG8_RESET;
      modCtl_r <= REG8_RESET;
      tselA_r <= REG8_RESET;
      tselB_r <= REG8_RESET;
    end else if (clockEn) begin
      if (wrPeriod) period_r <= wData_r;
      if (wrTb) tbCtl_r <= wData_r[TB_CFG_W-1:0];
      if (wrDutyW) dutyWrite_r <= wData_r;
      if (wrModCtl) modCtl_r <= wData_r;
      if (wrTselA) tselA_r <= wData_r;
      if (wrTselB) tselB_r <= wData_r;
    end
  end

  // Postscaler paces only its own flag; a new event wins over a clearing write.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      post_r <= '0;
      postFlag_r <= 1'b0;
    end else if (clockEn) begin
      if (wrTb) begin
        post_r <= '0;
      end else if (rollEv) begin
        post_r <= postEnd ? 4'h0 : post_r + 4'h1;
      end
      postFlag_r <= postEv || (wrTb ? (wData_r[TB_FLAG_BIT] && postFlag_r) : postFlag_r);
    end
  end

  // Duty shadow and hidden low latch.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      shadow_r <= '0;
    end else if (clockEn) begin
      if (modeOff) begin
        shadow_r <= '0;
      end else if (rollEv && pwmMode) begin
        shadow_r <= dutyNew;
      end else if (wrShadow && !pwmMode) begin
        shadow_r.high <= wData_r;
      end
    end
  end

  // Output pin: set at rollover, cleared on the duty match.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pwmPin_r <= 1'b0;
      pwmPinOe_r <= 1'b0;
    end else if (clockEn) begin
      pwmPinOe_r <= pwmMode && modCtl_r[MC_DRIVE_BIT];
      if (!pwmMode) begin
        pwmPin_r <= 1'b0;
      end else if (rollEv) begin
        pwmPin_r <= dutyNew != '0;
      end else if (matchEv) begin
        pwmPin_r <= 1'b0;
      end
    end
  end

  // Write channel: address and data taken in either order, answered after both.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= '0;
      wData_r <= REG8_RESET;
      wStrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (clockEn) begin
      if (awvalid && awready_r) begin
        awAddr_r <= awaddr;
        awHave_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        wData_r <= wdata[7:0];
        wStrb0_r <= wstrb[0];
        wHave_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wrFire) begin
        bvalid_r <= 1'b1;
        bresp_r <= (wrIdx != REG_NONE) ? RESP_OKAY : RESP_SLVERR;
        awHave_r <= 1'b0;
        wHave_r <= 1'b0;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Read channel.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdState_r <= RD_IDLE;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (clockEn) begin
      unique case (rdState_r)
        RD_IDLE: begin
          if (arvalid) begin
            rdata_r <= {{(DATA_W-8){1'b0}}, rdByte};
            rresp_r <= rdHit ? RESP_OKAY : RESP_SLVERR;
            rvalid_r <= 1'b1;
            arready_r <= 1'b0;
            rdState_r <= RD_RESP;
          end
        end
        RD_RESP: begin
          if (rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
            rdState_r <= RD_IDLE;
          end
        end
        default: begin
          rdState_r <= RD_IDLE;
          arready_r <= 1'b1;
          rvalid_r <= 1'b0;
        end
      endcase
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign pwmOutputPin = pwmPin_r;
  assign pwmOutputPinOe = pwmPinOe_r;

  // Helper for the period check: cycles since the last rollover with untouched setup.
  logic [15:0] periodCnt_r;
  logic cleanWin_r;
  wire logic [15:0] expectedPeriod =
    (16'(period_r) + 16'h0001) * (16'(subLast(preSel)) + 16'h0001);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      periodCnt_r <= '0;
      cleanWin_r <= 1'b0;
    end else if (clockEn) begin
      if (rollEv) begin
        periodCnt_r <= '0;
        cleanWin_r <= !wrCount;
      end else begin
        if (runOn) periodCnt_r <= periodCnt_r + 16'h0001;
        if (wrCount || wrPeriod || wrTb || !runOn) cleanWin_r <= 1'b0;
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  count_clear_a: assert property (rollEv && !wrCount |=> count_r == 8'h00)
    else $error("Count not cleared after rollover");
  pin_set_a: assert property (rollEv && pwmMode && dutyNew != '0 |=> pwmPin_r)
    else $error("Pin not set at rollover");
  zero_duty_a: assert property (rollEv && pwmMode && dutyNew == '0 |=> !pwmPin_r)
    else $error("Pin set with zero duty");
  shadow_load_a: assert property (rollEv && pwmMode && !modeOff |=> shadow_r == $past(dutyNew))
    else $error("Shadow not loaded at rollover");
  shadow_hold_a: assert property (clockEn && pwmMode && !rollEv |=> $stable(shadow_r))
    else $error("Shadow changed mid-period");
  match_clear_a: assert property (matchEv && !rollEv ##1 !rollEv |-> !pwmPin_r)
    else $error("Pin not cleared on duty match");
  over_period_a: assert property (clockEn && pwmMode && pwmPin_r && !rollEv
      && shadow_r > {period_r, 2'b11} && !wrPeriod && !wrCount && count_r <= period_r
      |=> pwmPin_r)
    else $error("Pin cleared with duty beyond period");
  period_len_a: assert property (rollEv && cleanWin_r |-> periodCnt_r + 16'h0001 == expectedPeriod)
    else $error("Period length wrong");
  mode_off_a: assert property (clockEn && modeOff |=> !pwmPin_r && shadow_r == '0)
    else $error("Module not reset when off");
  resp_hold_a: assert property (bvalid_r && !bready |=> bvalid_r)
    else $error("Write response dropped early");

  rollover_high_c: cover property (rollEv && pwmMode && dutyNew != '0 ##1 pwmPin_r);
  match_fall_c: cover property (matchEv && pwmPin_r ##1 !pwmPin_r);
  duty_over_c: cover property (rollEv && pwmMode && shadow_r > {period_r, 2'b11});
  post_flag_c: cover property (postEv && postSel != 4'h0);

endmodule

`default_nettype wire

// >>> test/pwm_load_model.sv
// Load model on the PWM output pin: measures high time and period in clock cycles.
// Assumes the pin is sampled on the rising clock edge and ignored while not driven.
`timescale 1ns/1ps
`default_nettype none

module pwm_load_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Pin as seen by the load.
  input wire logic pin,
  input wire logic oe,
  // Last measured figures.
  output int highLen,
  output int periodLen
);
  int cnt = 0;
  logic prev = 1'b0;

  // An undriven pin is treated as idle so stale levels never count as pulses.
  always @(posedge clock) begin
    if (sys_rst || !oe) begin
      cnt <= 0;
      prev <= 1'b0;
    end else begin
      prev <= pin;
      cnt <= cnt + 1;
      if (pin && !prev) begin
        periodLen <= cnt;
        cnt <= 1;
      end
      if (!pin && prev) begin
        highLen <= cnt;
      end
    end
  end
endmodule

`default_nettype wire

// >>> test/ccp_pwm_10bit_tb.sv
// Self-checking bench for the 10-bit PWM unit, driving its AXI4-Lite registers.
// Assumes the load model file is compiled first and one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module ccp_pwm_10bit_tb;
  import pwm_pkg::*;
  logic clock = 0, sys_rst = 1, clockEn = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid, pwmOutputPin, pwmOutputPinOe;
  logic [1:0] bresp, rresp, resp;
  int bad_count = 0, compares = 0, highLen, periodLen;

  ccp_pwm_10bit uut (.clock(clock), .sys_rst(sys_rst), .clockEn(clockEn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .pwmOutputPin(pwmOutputPin), .pwmOutputPinOe(pwmOutputPinOe));

  pwm_load_model load (.clock(clock), .sys_rst(sys_rst), .pin(pwmOutputPin),
    .oe(pwmOutputPinOe), .highLen(highLen), .periodLen(periodLen));

  initial begin
    forever #5 clock = ~clock;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrreg(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) bad_count++;
  endtask

  task automatic rdreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) bad_count++;
  endtask

  // Waits three whole periods, then compares the load's last measurement.
  task automatic measure(input int pre, input int duty, input int lim);
    int hi;
    repeat (3 * (lim + 1) * 4 * pre + 10) @(posedge clock);
    hi = highLen;
    check("period", periodLen, (lim + 1) * 4 * pre);
    check("high time", hi == duty * pre || hi == duty * pre + 1, 1);
  endtask

  task automatic hold(input logic lvl);
    logic ok;
    ok = 1'b1;
    repeat (200) begin
      @(posedge clock);
      #1 ok &= (pwmOutputPin === lvl);
    end
    check("pin level", ok, 1'b1);
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #150000;
    bad_count++;
    stop_test;
  end

  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rdreg(8'(i * 4), rd, resp);
      check("reset value", rd, (i == 1) ? 32'h000000ff : 32'h00000000);
    end
    rdreg(8'h20, rd, resp);
    check("unmapped read resp", resp, RESP_SLVERR);
    check("unmapped read data", rd, 32'h0);
    wrreg(8'h20, 8'h55, resp);
    check("unmapped write resp", resp, RESP_SLVERR);
    $display("test reset_and_map done");
    // Setup order: period, duty, pin drive, prescale and run, then mode.
    wrreg(8'h04, 8'h07, resp);
    wrreg(8'h0c, 8'h03, resp);
    wrreg(8'h14, 8'ha0, resp);
    wrreg(8'h08, 8'h04, resp);
    wrreg(8'h14, 8'hac, resp);
    for (int p = 0; p < 3; p++) begin
      wrreg(8'h08, {5'h00, 1'b1, 2'(p)}, resp);
      measure(1 << (2 * p), 14, 7);
    end
    rdreg(8'h00, rd, resp);
    check("count in range", rd <= 32'h7, 1'b1);
    $display("test prescale_and_duty done");
    @(posedge pwmOutputPin);
    wrreg(8'h0c, 8'h05, resp);
    rdreg(8'h10, rd, resp);
    check("shadow before rollover", rd, 32'h03);
    wrreg(8'h10, 8'h99, resp);
    check("shadow write resp", resp, RESP_OKAY);
    rdreg(8'h10, rd, resp);
    check("shadow read only", rd, 32'h03);
    measure(16, 22, 7);
    rdreg(8'h10, rd, resp);
    check("shadow after rollover", rd, 32'h05);
    $display("test buffered_update done");
    wrreg(8'h08, 8'h7c, resp);
    measure(1, 22, 7);
    rdreg(8'h08, rd, resp);
    check("flag before postscale", rd, 32'h7c);
    repeat (16 * 32) @(posedge clock);
    rdreg(8'h08, rd, resp);
    check("flag after postscale", rd, 32'hfc);
    wrreg(8'h08, 8'h7c, resp);
    rdreg(8'h08, rd, resp);
    check("flag cleared", rd, 32'h7c);
    $display("test postscale done");
    wrreg(8'h0c, 8'hff, resp);
    repeat (100) @(posedge clock);
    hold(1'b1);
    wrreg(8'h0c, 8'h00, resp);
    wrreg(8'h14, 8'h8c, resp);
    repeat (100) @(posedge clock);
    hold(1'b0);
    $display("test duty_extremes done");
    wrreg(8'h14, 8'h00, resp);
    repeat (2) @(posedge clock);
    #1;
    check("pin off", pwmOutputPin, 1'b0);
    check("drive off", pwmOutputPinOe, 1'b0);
    $display("test mode_off done");
    stop_test;
  end
endmodule

`default_nettype wire
